// *** common/lpw_pkg.sv ***
// Constants, register map and types for the low-power mode and wake-up controller
package lpw_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam int          ADR_W         = 5;
  localparam logic [4:0]  ADR_CMD       = 5'h00;
  localparam logic [4:0]  ADR_CLK_KEEP  = 5'h04;
  localparam logic [4:0]  ADR_ANA_KEEP  = 5'h08;
  localparam logic [4:0]  ADR_PERI_KEEP = 5'h0C;
  localparam logic [4:0]  ADR_WAKE_LO   = 5'h10;
  localparam logic [4:0]  ADR_WAKE_HI   = 5'h14;
  localparam logic [4:0]  ADR_STATUS    = 5'h18;

  // ----------------------------------------------------------------
  // Command bits, one-shot on write
  // ----------------------------------------------------------------
  localparam int CMD_SLEEP0 = 0;
  localparam int CMD_SLEEP1 = 1;
  localparam int CMD_DSLEEP = 2;
  localparam int CMD_DPD    = 3;
  localparam int CMD_FDPD   = 4;

  // ----------------------------------------------------------------
  // Field widths and positions
  // ----------------------------------------------------------------
  localparam int NUM_SRC  = 10;
  localparam int NUM_ANA  = 2;
  localparam int ANA_CMP  = 1;
  localparam int NUM_PERI = 8;
  localparam int NUM_WK   = 64;
  localparam int NUM_SER  = 8;
  localparam logic [NUM_SRC-1:0]  CLK_KEEP_RST  = 10'h000;
  localparam logic [NUM_ANA-1:0]  ANA_KEEP_RST  = 2'h0;
  localparam logic [NUM_PERI-1:0] PERI_KEEP_RST = 8'h00;
  localparam logic [31:0]         WAKE_EN_RST   = 32'h00000000;

  // Wake source bit positions in the 64-bit request vector
  localparam int WK_PIN_INT = 0;
  localparam int WK_WDOG0   = 1;
  localparam int WK_WDOG1   = 2;
  localparam int WK_RTC     = 3;
  localparam int WK_UTICK   = 4;
  localparam int WK_USB     = 5;
  localparam int WK_DMA     = 6;
  localparam int WK_DIGITAL_MICROPHONE_INTERFACE    = 7;
  localparam int WK_CMP     = 8;
  localparam int WK_SER_LO  = 16;

  // Status word positions
  localparam int ST_SLEEP_POS = 0;
  localparam int ST_STATE_POS = 4;
  localparam int ST_CAUSE_POS = 8;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_NS       = 100;
  localparam int SETTLE_NS    = 1000;
  localparam int SETTLE_CYC   = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
  localparam int WAKE_RST_NS  = 400;
  localparam int WAKE_RST_CYC = (WAKE_RST_NS + CLK_NS - 1) / CLK_NS;
  localparam int CNT_W        = 4;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    LPW_RUN,
    LPW_DSLEEP,
    LPW_RESTART,
    LPW_DPD,
    LPW_WAKE_RST
  } lpw_state_t;

  typedef struct packed {
    logic main_clk;
    logic periph_clk;
    logic main_pll;
    logic audio_pll;
    logic boot_rom;
    logic core_pwr;
    logic pin_hold;
    logic pin_hiz;
  } lpw_gate_t;

  localparam lpw_gate_t GATE_RUN = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0};

endpackage : lpw_pkg

// *** hdl/lpw_ctrl.sv ***
// Low-power mode and wake-up controller with a classic Wishbone slave
//
// Behaviour
// - Each of the two processors has its own independent sleep state.
// - Sleep gates that processor's clock until reset or interrupt.
// - Peripheral clocks stay on in sleep; their interrupts wake the processor.
// - Sleep and deep-sleep retain all state and hold pins at their level.
// - Deep-sleep stops processor, main and peripheral clocks; sources off unless kept.
// - Analog blocks off in deep-sleep unless selected to keep running.
// - Pin interrupts and selected peripherals may keep running in deep-sleep.
// - Main PLL, audio PLL and main clock always stop in deep-sleep.
// - Deep power-down removes power except always-on domain and wake pins.
// - Deep power-down exits only on reset pin, RTC event or power-IC pin; the first watchdog reset also exits it here.
// - The one-second alarm flag raises an RTC wake-up request.
// - Deep power-down loses contents, wakes as reset, tri-states pins.
// - Both power-down modes set identical on/off states; RTC stays configurable.
// - The comparator may run in deep-sleep but never wakes the chip.
// - Only the first watchdog wakes from deep-sleep or resets the chip.
// - Serial interfaces wake only as slaves, or as slow-clocked asynchronous ports.
// - USB activity needing a clock wakes the chip from deep-sleep.
// - Serial and microphone activity issues a hardware wake out of sleep.
// - DMA may keep running in deep-sleep and its interrupts wake the chip.
// - An interrupt wakes only if enabled in the processor's interrupt controller.
// - A deep-sleep source wakes only if enabled in a wake-start enable register.
//
// Local design decisions: the register addresses and the Wishbone slave port.
`timescale 1ns/10ps
`default_nettype none

module lpw_ctrl #(
  parameter int SETTLE    = lpw_pkg::SETTLE_CYC,
  parameter int RST_PULSE = lpw_pkg::WAKE_RST_CYC
) (
  input  wire  logic                          CLK,
  input  wire  logic                          SYS_RST,
  // Wishbone slave
  input  wire  logic                          CYC_I,
  input  wire  logic                          STB_I,
  input  wire  logic                          WE_I,
  input  wire  logic [3:0]                    SEL_I,
  input  wire  logic [lpw_pkg::ADR_W-1:0]     ADR_I,
  input  wire  logic [31:0]                   DAT_I,
  output logic       [31:0]                   DAT_O,
  output logic                                ACK_O,
  // Wake request sources
  input  wire  logic [lpw_pkg::NUM_WK-1:0]    IRQ,
  input  wire  logic [lpw_pkg::NUM_WK-1:0]    NVIC_EN0,
  input  wire  logic [lpw_pkg::NUM_WK-1:0]    NVIC_EN1,
  input  wire  logic [lpw_pkg::NUM_SER-1:0]   SER_SLAVE,
  input  wire  logic [lpw_pkg::NUM_SER-1:0]   USART_SLOW,
  input  wire  logic                          HARDWARE_ACTIVITY_WAKE,
  input  wire  logic                          ONE_SECOND_ALARM_FLAG,
  input  wire  logic                          RTC_WAKE_EVT,
  input  wire  logic                          POWER_IC_WAKE_PIN_N,
  input  wire  logic                          RESET_PIN_N,
  input  wire  logic                          PRIMARY_WATCHDOG_RST,
  input  wire  logic                          SUPPLY_GOOD,
  // Power and clock controls
  output logic [1:0]                          CPU_CLK_EN,
  output lpw_pkg::lpw_gate_t                  GATE,
  output logic [lpw_pkg::NUM_SRC-1:0]         SRC_EN,
  output logic [lpw_pkg::NUM_ANA-1:0]         ANA_EN,
  output logic [lpw_pkg::NUM_PERI-1:0]        PERI_RUN,
  output logic                                RTC_WAKE_IRQ,
  output logic                                CHIP_RESET
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  lpw_pkg::lpw_state_t             state_ff;
  lpw_pkg::lpw_state_t             nxt_state;
  logic [1:0]                      sleep_ff;
  logic [1:0]                      nxt_sleep;
  logic                            full_dpd_ff;
  logic [lpw_pkg::CNT_W-1:0]       cnt_ff;
  logic [lpw_pkg::CNT_W-1:0]       nxt_cnt;
  logic [lpw_pkg::NUM_SRC-1:0]     clk_keep_ff;
  logic [lpw_pkg::NUM_ANA-1:0]     ana_keep_ff;
  logic [lpw_pkg::NUM_PERI-1:0]    peri_keep_ff;
  logic [31:0]                     wake_lo_ff;
  logic [31:0]                     wake_hi_ff;
  logic [2:0]                      cause_ff;
  logic                            wb_req;
  logic                            wr_cmd;
  logic [lpw_pkg::NUM_WK-1:0]      irq_eff;
  logic                            ds_wake;
  logic                            dpd_wake;
  logic [1:0]                      slp_wake;
  lpw_pkg::lpw_gate_t              nxt_gate;
  logic [1:0]                      nxt_cpu_clk;

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  // Sources that may ever wake from deep-sleep
  function automatic logic [lpw_pkg::NUM_WK-1:0] ds_eligible(
    input logic [lpw_pkg::NUM_SER-1:0] slave,
    input logic [lpw_pkg::NUM_SER-1:0] slow
  );
    logic [lpw_pkg::NUM_WK-1:0] m;
    m = '1;
    m[lpw_pkg::WK_CMP]   = 1'b0;
    m[lpw_pkg::WK_WDOG1] = 1'b0;
    // Serial only as slave or slow
    m[lpw_pkg::WK_SER_LO +: lpw_pkg::NUM_SER] = slave | slow;
    return m;
  endfunction : ds_eligible

  function automatic logic [31:0] word_merge(
    input logic [31:0] old,
    input logic [31:0] dat,
    input logic [3:0]  sel
  );
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
    begin
      if (sel[i])
      begin
        r[i*8 +: 8] = dat[i*8 +: 8];
      end
    end
    return r;
  endfunction : word_merge

  // ----------------------------------------------------------------
  // Wishbone slave
  // ----------------------------------------------------------------
  assign wb_req = CYC_I & STB_I & ~ACK_O;
  assign wr_cmd = wb_req & WE_I & (ADR_I == lpw_pkg::ADR_CMD) & SEL_I[0];

  always_ff @(posedge CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      ACK_O <= 1'b0;
    end
    else
    begin
      ACK_O <= wb_req;
    end
  end

  always_ff @(posedge CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      DAT_O <= 32'h00000000;
    end
    else if (wb_req & ~WE_I)
    begin
      case (ADR_I)
        lpw_pkg::ADR_CLK_KEEP:  DAT_O <= 32'(clk_keep_ff);
        lpw_pkg::ADR_ANA_KEEP:  DAT_O <= 32'(ana_keep_ff);
        lpw_pkg::ADR_PERI_KEEP: DAT_O <= 32'(peri_keep_ff);
        lpw_pkg::ADR_WAKE_LO:   DAT_O <= wake_lo_ff;
        lpw_pkg::ADR_WAKE_HI:   DAT_O <= wake_hi_ff;
        lpw_pkg::ADR_STATUS:
        begin
          DAT_O <= (32'(sleep_ff) << lpw_pkg::ST_SLEEP_POS)
                 | (32'(state_ff) << lpw_pkg::ST_STATE_POS)
                 | (32'(cause_ff) << lpw_pkg::ST_CAUSE_POS);
        end
        default:                DAT_O <= 32'h00000000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  // Contents lost on power-down wake
  always_ff @(posedge CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      clk_keep_ff  <= lpw_pkg::CLK_KEEP_RST;
      ana_keep_ff  <= lpw_pkg::ANA_KEEP_RST;
      peri_keep_ff <= lpw_pkg::PERI_KEEP_RST;
      wake_lo_ff   <= lpw_pkg::WAKE_EN_RST;
      wake_hi_ff   <= lpw_pkg::WAKE_EN_RST;
    end
    else if (state_ff == lpw_pkg::LPW_WAKE_RST)
    begin
      clk_keep_ff  <= lpw_pkg::CLK_KEEP_RST;
      ana_keep_ff  <= lpw_pkg::ANA_KEEP_RST;
      peri_keep_ff <= lpw_pkg::PERI_KEEP_RST;
      wake_lo_ff   <= lpw_pkg::WAKE_EN_RST;
      wake_hi_ff   <= lpw_pkg::WAKE_EN_RST;
    end
    else if (wb_req & WE_I)
    begin
      case (ADR_I)
        lpw_pkg::ADR_CLK_KEEP:
          clk_keep_ff <= word_merge(32'(clk_keep_ff), DAT_I, SEL_I)
                         [lpw_pkg::NUM_SRC-1:0];
        lpw_pkg::ADR_ANA_KEEP:
          ana_keep_ff <= word_merge(32'(ana_keep_ff), DAT_I, SEL_I)
                         [lpw_pkg::NUM_ANA-1:0];
        lpw_pkg::ADR_PERI_KEEP:
          peri_keep_ff <= word_merge(32'(peri_keep_ff), DAT_I, SEL_I)
                          [lpw_pkg::NUM_PERI-1:0];
        lpw_pkg::ADR_WAKE_LO: wake_lo_ff <= word_merge(wake_lo_ff, DAT_I, SEL_I);
        lpw_pkg::ADR_WAKE_HI: wake_hi_ff <= word_merge(wake_hi_ff, DAT_I, SEL_I);
        default:              ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Wake decode
  // ----------------------------------------------------------------
  // Alarm flag feeds the RTC wake request
  assign irq_eff = IRQ | (lpw_pkg::NUM_WK'(ONE_SECOND_ALARM_FLAG) << lpw_pkg::WK_RTC);

  // Hardware activity wakes a sleeping processor
  // Interrupt must be enabled in that processor's controller
  assign slp_wake[0] = (|(irq_eff & NVIC_EN0)) | HARDWARE_ACTIVITY_WAKE;
  assign slp_wake[1] = (|(irq_eff & NVIC_EN1)) | HARDWARE_ACTIVITY_WAKE;

  // Comparator, second watchdog and master-mode serial excluded
  assign ds_wake = |(irq_eff & ds_eligible(SER_SLAVE, USART_SLOW)
                     & {wake_hi_ff, wake_lo_ff} & (NVIC_EN0 | NVIC_EN1));

  // Only the RTC or the power-IC pin; reset pin handled separately
  // Full power-down waits for supplies from outside
  assign dpd_wake = (ONE_SECOND_ALARM_FLAG | RTC_WAKE_EVT | ~POWER_IC_WAKE_PIN_N)
                    & (~full_dpd_ff | SUPPLY_GOOD);

  // ----------------------------------------------------------------
  // Mode sequencer
  // ----------------------------------------------------------------
  always_comb
  begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff;
    case (state_ff)
      lpw_pkg::LPW_RUN:
      begin
        if (wr_cmd & (DAT_I[lpw_pkg::CMD_DPD] | DAT_I[lpw_pkg::CMD_FDPD]))
        begin
          nxt_state = lpw_pkg::LPW_DPD;
        end
        else if (wr_cmd & DAT_I[lpw_pkg::CMD_DSLEEP])
        begin
          nxt_state = lpw_pkg::LPW_DSLEEP;
        end
      end
      lpw_pkg::LPW_DSLEEP:
      begin
        if (ds_wake)
        begin
          nxt_state = lpw_pkg::LPW_RESTART;
          nxt_cnt   = lpw_pkg::CNT_W'(SETTLE - 1);
        end
      end
      // Clocks settle before processor clock returns
      lpw_pkg::LPW_RESTART:
      begin
        if (cnt_ff == '0)
        begin
          nxt_state = lpw_pkg::LPW_RUN;
        end
        else
        begin
          nxt_cnt = cnt_ff - 1'b1;
        end
      end
      lpw_pkg::LPW_DPD:
      begin
        if (dpd_wake)
        begin
          nxt_state = lpw_pkg::LPW_WAKE_RST;
          nxt_cnt   = lpw_pkg::CNT_W'(RST_PULSE - 1);
        end
      end
      lpw_pkg::LPW_WAKE_RST:
      begin
        if (cnt_ff == '0)
        begin
          nxt_state = lpw_pkg::LPW_RUN;
        end
        else
        begin
          nxt_cnt = cnt_ff - 1'b1;
        end
      end
      default: nxt_state = lpw_pkg::LPW_RUN;
    endcase
    // First watchdog or reset pin restarts the chip from any mode
    if (PRIMARY_WATCHDOG_RST | ~RESET_PIN_N)
    begin
      nxt_state = lpw_pkg::LPW_WAKE_RST;
      nxt_cnt   = lpw_pkg::CNT_W'(RST_PULSE - 1);
    end
  end

  always_ff @(posedge CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      state_ff <= lpw_pkg::LPW_RUN;
      cnt_ff   <= '0;
    end
    else
    begin
      state_ff <= nxt_state;
      cnt_ff   <= nxt_cnt;
    end
  end

  always_ff @(posedge CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      full_dpd_ff <= 1'b0;
    end
    else if (state_ff == lpw_pkg::LPW_RUN && nxt_state == lpw_pkg::LPW_DPD)
    begin
      full_dpd_ff <= DAT_I[lpw_pkg::CMD_FDPD];
    end
  end

  always_ff @(posedge CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      cause_ff <= 3'h0;
    end
    else if (state_ff != lpw_pkg::LPW_WAKE_RST && nxt_state == lpw_pkg::LPW_WAKE_RST)
    begin
      cause_ff <= {dpd_wake, PRIMARY_WATCHDOG_RST, ~RESET_PIN_N};
    end
  end

  // ----------------------------------------------------------------
  // Per-processor sleep
  // ----------------------------------------------------------------
  // Independent sleep flags
  always_comb
  begin
    nxt_sleep = sleep_ff;
    for (int c = 0; c < 2; c++)
    begin
      if (slp_wake[c] | (nxt_state == lpw_pkg::LPW_WAKE_RST))
      begin
        nxt_sleep[c] = 1'b0;
      end
      else if (wr_cmd & DAT_I[lpw_pkg::CMD_SLEEP0 + c]
               & (state_ff == lpw_pkg::LPW_RUN))
      begin
        nxt_sleep[c] = 1'b1;
      end
    end
  end

  always_ff @(posedge CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      sleep_ff <= 2'b00;
    end
    else
    begin
      sleep_ff <= nxt_sleep;
    end
  end

  // ----------------------------------------------------------------
  // Output gating
  // ----------------------------------------------------------------
  always_comb
  begin
    nxt_gate    = lpw_pkg::GATE_RUN;
    nxt_cpu_clk = 2'b00;
    case (nxt_state)
      lpw_pkg::LPW_RUN:
      begin
        // Peripheral clocks untouched by processor sleep
        nxt_cpu_clk = ~nxt_sleep;
      end
      lpw_pkg::LPW_DSLEEP:
      begin
        nxt_gate.main_clk   = 1'b0;
        nxt_gate.periph_clk = 1'b0;
        nxt_gate.main_pll   = 1'b0;
        nxt_gate.audio_pll  = 1'b0;
        nxt_gate.boot_rom   = 1'b0;
        nxt_gate.pin_hold   = 1'b1;
      end
      lpw_pkg::LPW_RESTART:
      begin
        nxt_gate.pin_hold = 1'b1;
      end
      lpw_pkg::LPW_DPD:
      begin
        nxt_gate = '0;
        nxt_gate.pin_hiz = 1'b1;
      end
      lpw_pkg::LPW_WAKE_RST:
      begin
        nxt_gate.pin_hiz = 1'b1;
      end
      default: nxt_cpu_clk = 2'b00;
    endcase
  end

  always_ff @(posedge CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      GATE       <= lpw_pkg::GATE_RUN;
      CPU_CLK_EN <= 2'b11;
      SRC_EN     <= '1;
      ANA_EN     <= '1;
      PERI_RUN   <= '1;
      CHIP_RESET <= 1'b0;
    end
    else
    begin
      GATE       <= nxt_gate;
      CPU_CLK_EN <= nxt_cpu_clk;
      CHIP_RESET <= (nxt_state == lpw_pkg::LPW_WAKE_RST);
      case (nxt_state)
        lpw_pkg::LPW_DSLEEP:
        begin
          // Sources only as configured to stay on
          SRC_EN   <= clk_keep_ff;
          ANA_EN   <= ana_keep_ff;
          PERI_RUN <= peri_keep_ff;
        end
        lpw_pkg::LPW_DPD, lpw_pkg::LPW_WAKE_RST:
        begin
          // Same state for both power-down modes
          SRC_EN   <= '0;
          ANA_EN   <= '0;
          PERI_RUN <= '0;
        end
        default:
        begin
          SRC_EN   <= '1;
          ANA_EN   <= '1;
          PERI_RUN <= '1;
        end
      endcase
    end
  end

  always_ff @(posedge CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      RTC_WAKE_IRQ <= 1'b0;
    end
    else
    begin
      RTC_WAKE_IRQ <= ONE_SECOND_ALARM_FLAG;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_sleep_gates_cpu: assert property (@(posedge CLK) disable iff (SYS_RST)
    (state_ff == lpw_pkg::LPW_RUN && sleep_ff[0]) |-> !CPU_CLK_EN[0])
    else $error("sleeping cpu0 clock running");

  a_sleep_indep: assert property (@(posedge CLK) disable iff (SYS_RST)
    (state_ff == lpw_pkg::LPW_RUN && sleep_ff[0] && !sleep_ff[1]) |-> CPU_CLK_EN[1])
    else $error("cpu1 stopped by cpu0 sleep");

  a_sleep_periph: assert property (@(posedge CLK) disable iff (SYS_RST)
    (state_ff == lpw_pkg::LPW_RUN) |-> GATE.periph_clk)
    else $error("peripheral clock off in sleep");

  a_ds_clocks_off: assert property (@(posedge CLK) disable iff (SYS_RST)
    (state_ff == lpw_pkg::LPW_DSLEEP) |-> !GATE.main_clk && !GATE.main_pll
                                        && !GATE.audio_pll && GATE.pin_hold)
    else $error("deep-sleep clocks not stopped");

  a_ds_keep_src: assert property (@(posedge CLK) disable iff (SYS_RST)
    (state_ff == lpw_pkg::LPW_DSLEEP && $stable(clk_keep_ff)) |-> SRC_EN == clk_keep_ff)
    else $error("deep-sleep source enables wrong");

  a_ds_wake_gate: assert property (@(posedge CLK) disable iff (SYS_RST)
    (state_ff == lpw_pkg::LPW_DSLEEP && {wake_hi_ff, wake_lo_ff} == '0
     && RESET_PIN_N && !PRIMARY_WATCHDOG_RST) |=> state_ff == lpw_pkg::LPW_DSLEEP)
    else $error("deep-sleep left with no enabled source");

  a_cmp_no_wake: assert property (@(posedge CLK) disable iff (SYS_RST)
    (state_ff == lpw_pkg::LPW_DSLEEP && (irq_eff & ~(64'(1) << lpw_pkg::WK_CMP)) == '0
     && RESET_PIN_N && !PRIMARY_WATCHDOG_RST) |=> state_ff == lpw_pkg::LPW_DSLEEP)
    else $error("comparator woke deep-sleep");

  a_restart_order: assert property (@(posedge CLK) disable iff (SYS_RST)
    (state_ff == lpw_pkg::LPW_RESTART) |-> GATE.main_clk && GATE.periph_clk
                                           && CPU_CLK_EN == 2'b00)
    else $error("cpu clock before main clock settled");

  a_dpd_power: assert property (@(posedge CLK) disable iff (SYS_RST)
    (state_ff == lpw_pkg::LPW_DPD) |-> !GATE.core_pwr && GATE.pin_hiz && SRC_EN == '0)
    else $error("power-down outputs wrong");

  a_dpd_exit: assert property (@(posedge CLK) disable iff (SYS_RST)
    (state_ff == lpw_pkg::LPW_DPD && !dpd_wake && RESET_PIN_N && !PRIMARY_WATCHDOG_RST)
    |=> state_ff == lpw_pkg::LPW_DPD)
    else $error("power-down left without a wake source");

  a_dpd_reset_wake: assert property (@(posedge CLK) disable iff (SYS_RST)
    (state_ff == lpw_pkg::LPW_DPD && dpd_wake) |=> CHIP_RESET ##1 wake_lo_ff == '0)
    else $error("power-down wake not as reset");

  a_rtc_irq: assert property (@(posedge CLK) disable iff (SYS_RST)
    $rose(ONE_SECOND_ALARM_FLAG) |=> RTC_WAKE_IRQ)
    else $error("alarm flag did not raise rtc wake");

endmodule : lpw_ctrl

`default_nettype wire

// *** verif/lpw_src_model.sv ***
// Wake source and supply partner model
`timescale 1ns/10ps
`default_nettype none
module lpw_src_model (
  input  wire logic       clk,
  input  wire logic [6:0] src,
  input  wire logic       pwr_req,
  output logic [63:0]     irq,
  output logic            supply_good
);
  always_ff @(posedge clk) supply_good <= pwr_req;
  assign irq = src[6] ? 64'h0 : 64'h1 << src[5:0];
endmodule : lpw_src_model
`default_nettype wire

// *** verif/lpw_ctrl_tb.sv ***
// Self-checking bench for the low-power controller
`timescale 1ns/10ps
`default_nettype none
module lpw_ctrl_tb;
  logic clk = 0, rst = 1, cyc = 0, we = 0, hw = 0, alm = 0, pic_n = 1, pwr = 1;
  logic rpin_n = 1, wd = 0;
  logic [7:0] slv = 8'h00, peri;
  logic [4:0] adr = 0;
  logic [3:0] sel = 4'hF;
  logic [31:0] dat = 0, rd, keep, seed = 32'h7445;
  logic [63:0] nv = '1, irq;
  logic [6:0] src = 7'h40;
  logic [9:0] src_en;
  logic [1:0] cpu, ana;
  lpw_pkg::lpw_gate_t gate;
  logic ack, cres, rtc, sg;
  logic [31:0] exp_q[$];
  int n_fail = 0, n_checks = 0;
  lpw_ctrl #(.SETTLE(2), .RST_PULSE(2)) dut_u (.CLK(clk), .SYS_RST(rst), .CYC_I(cyc),
    .STB_I(cyc), .WE_I(we), .SEL_I(sel), .ADR_I(adr), .DAT_I(dat), .DAT_O(rd),
    .ACK_O(ack), .IRQ(irq), .NVIC_EN0(nv), .NVIC_EN1(nv), .SER_SLAVE(slv),
    .USART_SLOW(8'h00), .HARDWARE_ACTIVITY_WAKE(hw), .ONE_SECOND_ALARM_FLAG(alm),
    .RTC_WAKE_EVT(1'b0), .POWER_IC_WAKE_PIN_N(pic_n), .RESET_PIN_N(rpin_n),
    .PRIMARY_WATCHDOG_RST(wd), .SUPPLY_GOOD(sg), .CPU_CLK_EN(cpu), .GATE(gate),
    .SRC_EN(src_en), .ANA_EN(ana), .PERI_RUN(peri), .RTC_WAKE_IRQ(rtc), .CHIP_RESET(cres));
  lpw_src_model src_u (.clk(clk), .src(src), .pwr_req(pwr), .irq(irq), .supply_good(sg));
  initial forever #50 clk = ~clk;
  task automatic chk(string n, logic [31:0] s, logic [31:0] e);
    n_checks++;
    if (s !== e)
    begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic wb(logic w, logic [4:0] a, logic [31:0] d, logic [31:0] e);
    @(posedge clk);
    cyc <= 1;
    we <= w;
    adr <= a;
    dat <= d;
    if (!w) exp_q.push_back(e);
    do @(posedge clk); while (!ack);
    cyc <= 0;
    @(posedge clk);
  endtask : wb
  task automatic wt(int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask : wt
  task automatic wrap_up;
    if (exp_q.size() != 0) n_fail++;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : wrap_up
  // Read results checked when acked
  always @(posedge clk)
    if (ack && cyc && !we) chk("read", rd, exp_q.pop_front());
  initial
  begin
    #(100 * 2000);
    n_fail++;
    wrap_up();
  end
  initial
  begin
    repeat (6) @(posedge clk);
    rst <= 0;
    keep = $random(seed);
    chk("cpu", cpu, 2'b11);
    chk("gate", gate, lpw_pkg::GATE_RUN);
    wb(1, lpw_pkg::ADR_CLK_KEEP, keep, 0);
    wb(1, lpw_pkg::ADR_PERI_KEEP, keep, 0);
    wb(0, lpw_pkg::ADR_CLK_KEEP, 0, keep & 32'h3FF);
    nv <= 64'h0;
    src <= 7'h06;
    wb(1, lpw_pkg::ADR_CMD, 32'h1, 0);
    wt(3);
    chk("cpu", cpu, 2'b10);
    @(posedge clk);
    nv <= 64'h40;
    wt(2);
    chk("cpu", cpu, 2'b11);
    @(posedge clk);
    nv <= '1;
    src <= 7'h40;
    wb(1, lpw_pkg::ADR_CMD, 32'h2, 0);
    wt(2);
    chk("cpu", cpu, 2'b01);
    @(posedge clk);
    hw <= 1;
    wt(2);
    chk("cpu", cpu, 2'b11);
    @(posedge clk);
    hw <= 0;
    alm <= 1;
    wt(2);
    chk("rtc", rtc, 1);
    @(posedge clk);
    alm <= 0;
    wb(1, lpw_pkg::ADR_WAKE_LO, 32'h10106, 0);
    wb(1, lpw_pkg::ADR_CMD, 32'h4, 0);
    wt(1);
    chk("gate", gate[7:4], 4'h0);
    chk("hold", gate.pin_hold, 1);
    chk("src", src_en, keep[9:0]);
    chk("ana", ana, 0);
    chk("cpu", cpu, 0);
    chk("peri", peri, keep[7:0]);
    @(posedge clk);
    src <= 7'h08;
    wt(4);
    wb(0, lpw_pkg::ADR_STATUS, 0, 32'h10);
    src <= 7'h02;
    wt(4);
    wb(0, lpw_pkg::ADR_STATUS, 0, 32'h10);
    src <= 7'h10;
    wt(4);
    wb(0, lpw_pkg::ADR_STATUS, 0, 32'h10);
    src <= 7'h01;
    wt(8);
    chk("cpu", cpu, 2'b11);
    chk("gate", gate, lpw_pkg::GATE_RUN);
    @(posedge clk);
    src <= 7'h40;
    slv <= 8'h01;
    wb(1, lpw_pkg::ADR_CMD, 32'h4, 0);
    src <= 7'h10;
    wt(8);
    chk("cpu", cpu, 2'b11);
    @(posedge clk);
    src <= 7'h40;
    pwr <= 0;
    wb(1, lpw_pkg::ADR_CMD, 32'h10, 0);
    wt(1);
    chk("hiz", gate.pin_hiz, 1);
    chk("pwr", gate.core_pwr, 0);
    @(posedge clk);
    pic_n <= 0;
    wt(4);
    chk("rst", cres, 0);
    @(posedge clk);
    pwr <= 1;
    wt(3);
    chk("rst", cres, 1);
    @(posedge clk);
    pic_n <= 1;
    wt(6);
    wb(0, lpw_pkg::ADR_STATUS, 0, 32'h400);
    wb(0, lpw_pkg::ADR_CLK_KEEP, 0, 0);
    rpin_n <= 0;
    @(posedge clk);
    rpin_n <= 1;
    wt(1);
    chk("rst", cres, 1);
    wt(3);
    wb(0, lpw_pkg::ADR_STATUS, 0, 32'h100);
    wd <= 1;
    @(posedge clk);
    wd <= 0;
    wt(4);
    wb(0, lpw_pkg::ADR_STATUS, 0, 32'h200);
    wrap_up();
  end
endmodule : lpw_ctrl_tb
`default_nettype wire
